//--- rtl/enc_cfg_pkg.sv
// shared offsets, field positions, reset values and encoder type codes
package enc_cfg_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAG = 8'h04;
	localparam logic [7:0] OFF_TURNS = 8'h08;
	localparam logic [7:0] OFF_LPR = 8'h0c;
	localparam logic [7:0] OFF_POS_LO = 8'h10;
	localparam logic [7:0] OFF_POS_HI = 8'h14;
	localparam logic [7:0] OFF_ELC = 8'h18;
	localparam logic [7:0] OFF_POLE = 8'h1c;
	localparam logic [7:0] OFF_REVLEN = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	// control and pole register field positions
	localparam int CTRL_INHIBIT = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_LINEAR_ROTARY = 2;
	localparam int CTRL_AUTOCFG = 3;
	localparam int CTRL_TYPE_LSB = 4;
	localparam int POLE_COUNT_LSB = 16;
	// reset values, limits and masks
	localparam logic [7:0] TURNS_RESET = 8'h10;
	localparam logic [4:0] TURNS_LIMIT = 5'h10;
	localparam logic [7:0] RATIO_SHOWN = 8'hff;
	localparam logic [18:0] LPR_RESET = 19'h00400;
	localparam logic [15:0] POLE_PITCH_RESET = 16'h0001;
	localparam logic [7:0] POLE_COUNT_RESET = 8'h02;
	localparam logic [15:0] FULL_TURNS_MASK = 16'hffff;
	typedef enum logic [3:0] {
		quadrature_type = 4'h0,
		freq_dir_type = 4'h1,
		fwd_rev_type = 4'h2,
		quadrature_commutation_type = 4'h3,
		freq_dir_commutation_type = 4'h4,
		fwd_rev_commutation_type = 4'h5,
		sincos_plain_type = 4'h6,
		sincos_comms_h_type = 4'h7,
		sincos_comms_e_type = 4'h8,
		sincos_synchronous_serial_type = 4'h9,
		serial_comms_e_type = 4'ha,
		serial_synchronous_type = 4'hb
	} enc_type_t;
endpackage

//--- rtl/marker_sync.sv
// three-stage synchroniser with agreement filter for the marker pin
`timescale 1ns/1ns
module marker_sync (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// level moves only when the two late stages agree
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			level_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end

	assign level_out = level_ff;
endmodule

//--- rtl/encoder_marker_turns_config.sv
// encoder marker, turns counter and line-count configuration with apb registers
// How it works
// - marker flag sets on each marker event; only software clears it
// - inhibit 0: marker resets position and sets flag; inhibit 1: flag only
// - marker mode zero clears position and fine position, keeps revolutions
// - marker mode one clears revolutions, position and fine position together
// - marker acts only for incremental and plain sine-cosine types
// - turns bits zero holds revolution count at zero
// - nonzero turns bits masks revolution count, wrapping after all ones
// - turns bits above 16 act as 16
// - turns bits reset to 16
// - linear comms encoder: no mask, full 16-bit revolution count
// - linear comms: turns bits is sine period to comms lsb ratio
// - auto ratio above 255 kept inside, shows 255, locks turns writes
// - auto-config enabled runs at power-up and every encoder init
// - turns bits and line count take effect only with drive disabled
// - line count clamped to one except servo-variant servo or pure serial
// - equivalent lines: lines, half lines, or sine periods by type
// - linear revolution equals pole pitch times pole count
// - position held as 48 bits: turns, position, fine position
// - revolution count rolls over as sixteen-bit counter only with turns bits of 16 or more, or linear comms
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module encoder_marker_turns_config #(
	parameter logic AUTO_SAVED = 1'b1,
	parameter int LPR_W = 19
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic marker_pin,
	input wire logic drive_enabled,
	input wire logic servo_mode,
	input wire logic pos_valid,
	input wire logic [31:0] pos_delta,
	input wire logic init_valid,
	input wire logic [47:0] init_position,
	input wire logic enc_init,
	input wire logic autocfg_done,
	input wire logic [15:0] autocfg_ratio,
	output logic autocfg_start,
	output logic [15:0] revolution_count,
	output logic [15:0] position_word,
	output logic [15:0] fine_position,
	output logic [LPR_W-1:0] equivalent_line_count,
	output logic [15:0] linear_ratio,
	output logic [23:0] rev_length
);
	import enc_cfg_pkg::*;

	logic marker_lvl;
	logic marker_prev_ff;
	logic marker_rise;
	logic marker_types;
	logic marker_evt;
	logic inhibit_ff;
	logic mode_ff;
	logic linear_rotary_ff;
	logic autocfg_en_ff;
	enc_type_t type_ff;
	logic flag_ff;
	logic [7:0] turns_bits_ff;
	logic [7:0] turns_act_ff;
	logic [LPR_W-1:0] lpr_ff;
	logic [LPR_W-1:0] lpr_act_ff;
	logic [15:0] pole_pitch_ff;
	logic [7:0] pole_count_ff;
	logic ratio_lock_ff;
	logic [15:0] big_ratio_ff;
	logic boot_ff;
	logic autocfg_start_ff;
	logic [15:0] rev_ff;
	logic [15:0] pos_ff;
	logic [15:0] fine_ff;
	logic [LPR_W-1:0] elc_ff;
	logic [23:0] rev_len_ff;
	logic [31:0] prdata_ff;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic flag_clr_wr;
	logic turns_wr;
	logic linear_comms;
	logic [15:0] turns_mask;
	logic [4:0] turns_eff;
	logic [47:0] nxt_pos;
	logic [LPR_W-1:0] lpr_clamped;
	logic lpr_zero_ok;
	logic [31:0] rd_mux;

	marker_sync u_marker_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_in(marker_pin),
		.level_out(marker_lvl)
	);

	// apb decode, zero wait states
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign flag_clr_wr = wr_en && (paddr == OFF_FLAG) && !pwdata[0];
	assign turns_wr = wr_en && (paddr == OFF_TURNS);

	always_comb begin
		if (paddr == OFF_CTRL) begin
			mapped = 1'b1;
		end else if (paddr == OFF_FLAG || paddr == OFF_TURNS || paddr == OFF_LPR) begin
			mapped = 1'b1;
		end else if (paddr == OFF_POS_LO || paddr == OFF_POS_HI || paddr == OFF_ELC) begin
			mapped = 1'b1;
		end else if (paddr == OFF_POLE || paddr == OFF_REVLEN || paddr == OFF_STATUS) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	assign pslverr = psel && penable && !mapped;

	always_comb begin
		if (paddr == OFF_CTRL) begin
			rd_mux = {24'h000000, type_ff, autocfg_en_ff, linear_rotary_ff, mode_ff, inhibit_ff};
		end else if (paddr == OFF_FLAG) begin
			rd_mux = {31'h00000000, flag_ff};
		end else if (paddr == OFF_TURNS) begin
			rd_mux = {24'h000000, turns_bits_ff};
		end else if (paddr == OFF_LPR) begin
			rd_mux = 32'(lpr_ff);
		end else if (paddr == OFF_POS_LO) begin
			rd_mux = {pos_ff, fine_ff};
		end else if (paddr == OFF_POS_HI) begin
			rd_mux = {16'h0000, rev_ff};
		end else if (paddr == OFF_ELC) begin
			rd_mux = 32'(elc_ff);
		end else if (paddr == OFF_POLE) begin
			rd_mux = {8'h00, pole_count_ff, pole_pitch_ff};
		end else if (paddr == OFF_REVLEN) begin
			rd_mux = {8'h00, rev_len_ff};
		end else if (paddr == OFF_STATUS) begin
			rd_mux = {15'h0000, ratio_lock_ff, linear_ratio};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prdata_ff <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_ff <= rd_mux;
		end
	end
	assign prdata = prdata_ff;

	// control register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			inhibit_ff <= 1'b0;
			mode_ff <= 1'b0;
			linear_rotary_ff <= 1'b1;
			autocfg_en_ff <= AUTO_SAVED;
			type_ff <= quadrature_type;
		end else if (wr_en && paddr == OFF_CTRL) begin
			inhibit_ff <= pwdata[CTRL_INHIBIT];
			mode_ff <= pwdata[CTRL_MODE];
			linear_rotary_ff <= pwdata[CTRL_LINEAR_ROTARY];
			autocfg_en_ff <= pwdata[CTRL_AUTOCFG];
			type_ff <= enc_type_t'(pwdata[CTRL_TYPE_LSB +: 4]);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lpr_ff <= LPR_RESET;
			pole_pitch_ff <= POLE_PITCH_RESET;
			pole_count_ff <= POLE_COUNT_RESET;
		end else if (wr_en && paddr == OFF_LPR) begin
			lpr_ff <= pwdata[LPR_W-1:0];
		end else if (wr_en && paddr == OFF_POLE) begin
			pole_pitch_ff <= pwdata[15:0];
			pole_count_ff <= pwdata[POLE_COUNT_LSB +: 8];
		end
	end

	// turns bits, auto-config result wins over a software write
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			turns_bits_ff <= TURNS_RESET;
			ratio_lock_ff <= 1'b0;
			big_ratio_ff <= 16'h0000;
		end else if (autocfg_done) begin
			if (autocfg_ratio > 16'(RATIO_SHOWN)) begin
				turns_bits_ff <= RATIO_SHOWN;
				ratio_lock_ff <= 1'b1;
				big_ratio_ff <= autocfg_ratio;
			end else begin
				turns_bits_ff <= autocfg_ratio[7:0];
				ratio_lock_ff <= 1'b0;
			end
		end else if (turns_wr && !ratio_lock_ff) begin
			turns_bits_ff <= pwdata[7:0];
		end
	end

	// background sampling, applied only while the output stage is off
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			turns_act_ff <= TURNS_RESET;
			lpr_act_ff <= LPR_RESET;
		end else if (!drive_enabled) begin
			turns_act_ff <= turns_bits_ff;
			lpr_act_ff <= lpr_ff;
		end
	end

	assign linear_ratio = ratio_lock_ff ? big_ratio_ff : {8'h00, turns_act_ff};

	// auto-config request at power-up and each encoder init
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			boot_ff <= 1'b1;
			autocfg_start_ff <= 1'b0;
		end else begin
			boot_ff <= 1'b0;
			autocfg_start_ff <= autocfg_en_ff && (boot_ff || enc_init);
		end
	end
	assign autocfg_start = autocfg_start_ff;

	// marker detection
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			marker_prev_ff <= 1'b0;
		end else begin
			marker_prev_ff <= marker_lvl;
		end
	end
	assign marker_rise = marker_lvl && !marker_prev_ff;
	assign marker_types = (type_ff <= sincos_plain_type);
	assign marker_evt = marker_rise && marker_types;

	// set wins over the software clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flag_ff <= 1'b0;
		end else if (marker_evt) begin
			flag_ff <= 1'b1;
		end else if (flag_clr_wr) begin
			flag_ff <= 1'b0;
		end
	end

	// turns mask
	assign linear_comms = !linear_rotary_ff && (type_ff >= sincos_comms_h_type)
		&& (type_ff <= sincos_synchronous_serial_type);
	assign turns_eff = (turns_act_ff > 8'(TURNS_LIMIT)) ? TURNS_LIMIT : turns_act_ff[4:0];
	always_comb begin
		if (linear_comms) begin
			turns_mask = FULL_TURNS_MASK;
		end else if (turns_eff == 5'h00) begin
			turns_mask = 16'h0000;
		end else begin
			turns_mask = 16'((17'h00001 << turns_eff) - 17'h00001);
		end
	end

	// 48-bit position: turns, position, fine
	always_comb begin
		if (init_valid) begin
			nxt_pos = init_position;
		end else if (pos_valid) begin
			nxt_pos = {rev_ff, pos_ff, fine_ff} + {{16{pos_delta[31]}}, pos_delta};
		end else begin
			nxt_pos = {rev_ff, pos_ff, fine_ff};
		end
		if (marker_evt && !inhibit_ff && !init_valid) begin
			nxt_pos[31:0] = 32'h00000000;
			if (mode_ff) begin
				nxt_pos[47:32] = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rev_ff <= 16'h0000;
			pos_ff <= 16'h0000;
			fine_ff <= 16'h0000;
		end else begin
			rev_ff <= nxt_pos[47:32] & turns_mask;
			pos_ff <= nxt_pos[31:16];
			fine_ff <= nxt_pos[15:0];
		end
	end
	assign revolution_count = rev_ff;
	assign position_word = pos_ff;
	assign fine_position = fine_ff;

	// equivalent lines and linear revolution length
	assign lpr_zero_ok = (servo_mode && type_ff >= quadrature_commutation_type
		&& type_ff <= fwd_rev_commutation_type) || (type_ff >= serial_comms_e_type);
	assign lpr_clamped = (lpr_act_ff == '0 && !lpr_zero_ok) ? LPR_W'(1) : lpr_act_ff;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			elc_ff <= LPR_RESET;
			rev_len_ff <= 24'h000000;
		end else begin
			case (type_ff)
				freq_dir_type, fwd_rev_type, freq_dir_commutation_type,
				fwd_rev_commutation_type: begin
					elc_ff <= lpr_clamped >> 1;
				end
				default: begin
					elc_ff <= lpr_clamped;
				end
			endcase
			rev_len_ff <= 24'(pole_pitch_ff) * 24'(pole_count_ff);
		end
	end
	assign equivalent_line_count = elc_ff;
	assign rev_length = rev_len_ff;

	// checks
	sequence marker_edge_s;
		(!marker_prev_ff && marker_types) ##1 marker_prev_ff;
	endsequence

	flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_evt |=> flag_ff)
		else $error("marker flag not set by event");
	flag_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		flag_ff && !flag_clr_wr |=> flag_ff)
		else $error("marker flag cleared without software");
	pos_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_evt && !inhibit_ff && !init_valid |=> pos_ff == 16'h0000 && fine_ff == 16'h0000)
		else $error("marker did not reset position");
	inhibit_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_evt && inhibit_ff && !init_valid && !pos_valid |=> $stable(pos_ff) && flag_ff)
		else $error("inhibited marker changed position");
	turns_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_evt && !inhibit_ff && !mode_ff && !init_valid && !pos_valid
		&& $stable(turns_mask) |=> $stable(rev_ff))
		else $error("conventional marker changed turns");
	full_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_evt && !inhibit_ff && mode_ff && !init_valid |=> rev_ff == 16'h0000)
		else $error("full marker reset kept turns");
	type_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_rise && !marker_types && !flag_ff |=> !flag_ff)
		else $error("marker acted for excluded type");
	sync_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
		marker_edge_s |-> flag_ff)
		else $error("marker edge lost");
	turns_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
		1'b1 |=> (rev_ff & ~$past(turns_mask)) == 16'h0000)
		else $error("revolution count outside mask");
	ratio_lock_a: assert property (@(posedge clk_sys) disable iff (reset)
		ratio_lock_ff && turns_wr && !autocfg_done |=> turns_bits_ff == RATIO_SHOWN)
		else $error("locked turns bits overwritten");
	drive_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		drive_enabled |=> $stable(turns_act_ff) && $stable(lpr_act_ff))
		else $error("settings changed with drive enabled");
	lpr_clamp_a: assert property (@(posedge clk_sys) disable iff (reset)
		!lpr_zero_ok |-> lpr_clamped != '0)
		else $error("line count not clamped");
endmodule

//--- tb/encoder_model.sv
// encoder model driving the marker pin and position updates
`timescale 1ns/1ns
module encoder_model (
	input wire logic clk_sys,
	output logic marker_pin,
	output logic pos_valid,
	output logic [31:0] pos_delta,
	output logic init_valid,
	output logic [47:0] init_position
);
	initial begin
		marker_pin = 0;
		pos_valid = 0;
		init_valid = 0;
		pos_delta = 0;
		init_position = 0;
	end
	// held well past the synchroniser depth, one rise per event
	task marker;
		@(posedge clk_sys);
		marker_pin <= 1;
		repeat (6) @(posedge clk_sys);
		marker_pin <= 0;
		repeat (6) @(posedge clk_sys);
	endtask
	// absolute load; data scrambled once the strobe drops
	task load(input logic [47:0] p);
		@(posedge clk_sys);
		init_valid <= 1;
		init_position <= p;
		@(posedge clk_sys);
		init_valid <= 0;
		init_position <= ~p;
	endtask
	task step(input logic [31:0] d);
		@(posedge clk_sys);
		pos_valid <= 1;
		pos_delta <= d;
		@(posedge clk_sys);
		pos_valid <= 0;
		pos_delta <= ~d;
	endtask
endmodule

//--- tb/encoder_marker_turns_config_tb.sv
// self-checking bench for the marker, turns and line-count block
`timescale 1ns/1ns
module encoder_marker_turns_config_tb;
	import enc_cfg_pkg::*;
	logic clk_sys = 0;
	logic reset = 1;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, rst;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, pos_delta;
	logic marker_pin, drive_enabled = 0, servo_mode = 0, pos_valid, init_valid;
	logic [47:0] init_position;
	logic enc_init = 0, autocfg_done = 0, autocfg_start;
	logic [15:0] autocfg_ratio = 0, revolution_count, position_word, fine_position;
	logic [15:0] linear_ratio;
	logic [18:0] equivalent_line_count, lpr;
	logic [23:0] rev_length;
	int bad_count = 0, checks = 0, seed = 10843, t, k, n, m;
	always #2 clk_sys = ~clk_sys;
	encoder_marker_turns_config dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .marker_pin, .drive_enabled, .servo_mode,
		.pos_valid, .pos_delta, .init_valid, .init_position, .enc_init, .autocfg_done,
		.autocfg_ratio, .autocfg_start, .revolution_count, .position_word,
		.fine_position, .equivalent_line_count, .linear_ratio, .rev_length);
	encoder_model enc (.clk_sys, .marker_pin, .pos_valid, .pos_delta, .init_valid,
		.init_position);
	task chk(input string n, input logic [47:0] s, input logic [47:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task done_pulse(input logic [15:0] r);
		@(posedge clk_sys);
		autocfg_done <= 1;
		autocfg_ratio <= r;
		@(posedge clk_sys);
		autocfg_done <= 0;
		autocfg_ratio <= ~r;
	endtask
	function automatic logic [18:0] elc_exp(input logic [3:0] ty, input logic [18:0] l,
		input logic sv);
		logic [18:0] c;
		c = (l == 0 && !((ty >= 3 && ty <= 5 && sv) || ty >= 10)) ? 19'h1 : l;
		return (ty inside {1, 2, 4, 5}) ? c >> 1 : c;
	endfunction
	task summarize;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("boot_start", autocfg_start, 1);
		apb(0, OFF_TURNS, 0);
		chk("turns_reset", rd[7:0], TURNS_RESET);
		apb(0, OFF_FLAG, 0);
		chk("flag_reset", rd[0], 0);
		chk("mapped_ok", err, 0);
		apb(0, 8'h3c, 0);
		chk("unmapped_err", err, 1);
		tick(1);
		chk("elc_reset", equivalent_line_count, 1024);
		// marker: inhibit and mode combinations, one ignored type, plain sine-cosine
		for (k = 0; k < 6; k++) begin
			t = (k == 4) ? 7 : (k == 5) ? 6 : k;
			apb(1, OFF_CTRL, {24'h0, t[3:0], 2'b01, k[1], k[0]});
			enc.load(48'h0005_abcd_1234);
			enc.marker();
			rst = (k != 4) && !k[0];
			apb(0, OFF_FLAG, 0);
			chk("flag_set", rd[0], k != 4);
			chk("pos", {position_word, fine_position}, rst ? 0 : 32'habcd1234);
			chk("rev", revolution_count, (rst && k[1]) ? 0 : 5);
			apb(1, OFF_FLAG, 1);
			apb(0, OFF_FLAG, 0);
			chk("flag_kept", rd[0], k != 4);
			apb(1, OFF_FLAG, 0);
			apb(0, OFF_FLAG, 0);
			chk("flag_clr", rd[0], 0);
		end
		apb(1, OFF_CTRL, 32'h04);
		drive_enabled <= 1;
		apb(1, OFF_TURNS, 0);
		enc.load(48'h1234_0000_0000);
		tick(3);
		chk("rev_held", revolution_count, 16'h1234);
		@(posedge clk_sys);
		drive_enabled <= 0;
		tick(3);
		chk("rev_zero", revolution_count, 0);
		apb(1, OFF_TURNS, 5);
		enc.load(48'h001f_ffff_ffff);
		tick(2);
		chk("rev_31", revolution_count, 31);
		enc.step(1);
		tick(2);
		chk("wrap5", {revolution_count, position_word, fine_position}, 0);
		apb(1, OFF_TURNS, 17 + {$random(seed)} % 239);
		enc.load(48'hffff_ffff_ffff);
		tick(3);
		chk("rev_max", revolution_count, 16'hffff);
		enc.step(1);
		tick(2);
		chk("wrap16", {revolution_count, position_word, fine_position}, 0);
		enc.step(-1);
		tick(2);
		chk("back", {revolution_count, position_word, fine_position}, '1);
		// linear comms: no mask on turns
		apb(1, OFF_CTRL, 32'h70);
		apb(1, OFF_TURNS, 5);
		enc.load(48'h1234_0000_0000);
		tick(3);
		chk("rev_linear", revolution_count, 16'h1234);
		chk("ratio", linear_ratio, 5);
		// random drive enable: settings follow only while the drive is off
		n = 5;
		for (t = 0; t < 8; t++) begin
			k = $random(seed);
			@(posedge clk_sys);
			drive_enabled <= k[8];
			apb(1, OFF_TURNS, {24'h0, k[7:0]});
			tick(2);
			if (!k[8])
				n = k[7:0];
			chk("ratio_bg", linear_ratio, n);
		end
		@(posedge clk_sys);
		drive_enabled <= 0;
		for (t = 0; t < 12; t++) begin
			lpr = (t % 4 == 3) ? 19'h0 : 19'({$random(seed)} % 500001);
			apb(1, OFF_CTRL, {24'h0, t[3:0], 4'b0100});
			servo_mode <= t[0];
			apb(1, OFF_LPR, {13'h0, lpr});
			tick(3);
			chk("elc", equivalent_line_count, elc_exp(t[3:0], lpr, t[0]));
		end
		k = $random(seed);
		apb(1, OFF_POLE, {8'h0, k[23:0]});
		tick(3);
		chk("rev_len", rev_length, k[15:0] * k[23:16]);
		apb(1, OFF_CTRL, 32'h0c);
		// random train of init pulses, one start per cycle that enc_init is high
		k = $random(seed) | 1;
		n = $countones(k[7:0]);
		m = 0;
		for (t = 0; t < 10; t++) begin
			enc_init <= (t < 8) ? k[t] : 1'b0;
			@(negedge clk_sys);
			if (autocfg_start === 1'b1)
				m++;
			@(posedge clk_sys);
		end
		chk("autocfg_start", m, n);
		done_pulse(300);
		apb(0, OFF_TURNS, 0);
		chk("big_ratio", rd[7:0], RATIO_SHOWN);
		chk("big_kept", linear_ratio, 300);
		apb(1, OFF_TURNS, 7);
		apb(0, OFF_TURNS, 0);
		chk("locked", rd[7:0], RATIO_SHOWN);
		done_pulse(9);
		apb(1, OFF_TURNS, 7);
		apb(0, OFF_TURNS, 0);
		chk("unlocked", rd[7:0], 7);
		summarize();
	end
endmodule
